// file: logic/swire_pkg.sv
// constants and helpers shared by both ends of the single-wire link
// assumes one 25 MHz system clock at each end
package swire_pkg;

  // ****************************************
  // timing and framing
  // ****************************************
  localparam int unsigned CLK_HZ             = 25_000_000;
  localparam int unsigned HOST_BAUD          = 250_000;
  localparam logic [15:0] HOST_BIT_CLKS      = 16'(CLK_HZ / HOST_BAUD);
  localparam logic [15:0] MIN_BIT_CLKS       = 16'h0010;
  localparam logic [15:0] RESET_BIT_CLKS     = 16'h0064;
  localparam logic [3:0]  STOP_POS           = 4'h9;
  localparam logic [6:0]  TIMEOUT_BITS       = 7'h3F;
  localparam logic [6:0]  BYTE_BITS          = 7'h0A;
  localparam logic [6:0]  RECOVER_BITS       = 7'h0C;
  localparam logic [7:0]  RELEASE_BITS       = 8'h04;
  localparam logic [7:0]  DELAY_STEP_BITS    = 8'h08;
  localparam logic [3:0]  DELAY_MIN_STEPS    = 4'h1;
  localparam logic [7:0]  REPLY_TIMEOUT_BITS = 8'hC8;

  // ****************************************
  // datagram layout
  // ****************************************
  localparam logic [7:0]  SYNC_BYTE      = 8'h05;
  localparam logic [3:0]  SYNC_NIBBLE    = 4'h5;
  localparam logic [7:0]  REPLY_ADDR     = 8'hFF;
  localparam int unsigned WRITE_FLAG_POS = 7;
  localparam logic [2:0]  WRITE_LAST     = 3'h7;
  localparam logic [2:0]  READ_LAST      = 3'h3;
  localparam logic [7:0]  CRC_POLY       = 8'h07;
  localparam logic [7:0]  CRC_SEED       = 8'h00;
  localparam logic [7:0]  ACK_RESET      = 8'h00;

  // ****************************************
  // helpers
  // ****************************************
  // check update over one byte, lsb first
  function automatic logic [7:0] crc8_byte(input logic [7:0] crc_in, input logic [7:0] data);
    logic [7:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc8_byte

  // byte at a position of an eight byte datagram
  function automatic logic [7:0] dg_byte(input logic [2:0] idx, input logic [7:0] addr,
                                         input logic [7:0] regb, input logic [31:0] data,
                                         input logic [7:0] crc);
    logic [7:0] b;
    b = SYNC_BYTE;
    unique case (idx)
      3'h0: b = SYNC_BYTE;
      3'h1: b = addr;
      3'h2: b = regb;
      3'h3: b = data[31:24];
      3'h4: b = data[23:16];
      3'h5: b = data[15:8];
      3'h6: b = data[7:0];
      3'h7: b = crc;
    endcase
    return b;
  endfunction : dg_byte

endpackage : swire_pkg

// file: logic/swire_if.sv
// shared single wire between host and device
// assumes an idle-high line: a party not driving leaves it high
interface swire_if;
  logic host_tx;
  logic host_oe;
  logic dev_tx;
  logic dev_oe;
  logic line;

  // wired level seen by both ends
  assign line = (host_oe ? host_tx : 1'b1) & (dev_oe ? dev_tx : 1'b1);

  modport device (input line, output dev_tx, output dev_oe);
  modport host (input line, output host_tx, output host_oe);
endinterface : swire_if

// file: logic/swire_device.sv
// device end of the single-wire datagram link: receiver, check, write ack counter, read reply
// assumes the line passes a two flop synchroniser; rd_data is valid while rd_req is high
module swire_device
  import swire_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  swire_if.device          link,
  input  wire logic [7:0]  node_address,
  input  wire logic [3:0]  reply_delay_setting,
  input  wire logic [31:0] rd_data,
  output logic             wr_valid,
  output logic [6:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic             rd_req,
  output logic [6:0]       rd_addr,
  output logic             dg_valid,
  output logic [7:0]       ack_count
);

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_SYNC = 3'h1, RX_BITS = 3'h3, RX_STOP = 3'h2, RX_GAP = 3'h6, RX_RECOVER = 3'h7
  } rx_state_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0, TX_WAIT = 2'h1, TX_SEND = 2'h3, TX_HOLD = 2'h2
  } tx_state_t;

  logic        meta_reg;
  logic        line_reg;
  logic        line_d_reg;
  rx_state_t   rx_state_reg;
  logic [17:0] cnt_reg;
  logic        edge_reg;
  logic [15:0] period_reg;
  logic [16:0] timer_reg;
  logic [2:0]  bit_idx_reg;
  logic [7:0]  shift_reg;
  logic [2:0]  byte_idx_reg;
  logic [6:0]  gap_reg;
  logic        byte_done_reg;
  logic [7:0]  crc_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  cmd_reg;
  logic [31:0] data_reg;
  tx_state_t   tx_state_reg;
  logic [15:0] tx_timer_reg;
  logic [7:0]  tx_bits_reg;
  logic [9:0]  tx_frame_reg;
  logic [3:0]  tx_nbit_reg;
  logic [2:0]  tx_idx_reg;
  logic [7:0]  tx_crc_reg;
  logic [31:0] tx_data_reg;
  logic [6:0]  tx_reg_reg;
  logic        tx_out_reg;
  logic        tx_oe_reg;

  logic        fall;
  logic [15:0] meas;
  logic [16:0] per_m1;
  logic        rx_last;
  logic        tx_tick;
  logic [2:0]  load_idx;
  logic [7:0]  load_byte;

  assign fall    = line_d_reg & ~line_reg;
  assign meas    = cnt_reg[17:2];
  assign per_m1  = {1'b0, period_reg} - 17'h00001;
  assign rx_last = (byte_idx_reg == WRITE_LAST) || (byte_idx_reg == READ_LAST && !cmd_reg[WRITE_FLAG_POS]);
  assign tx_tick = (tx_timer_reg == 16'h0000);
  assign load_idx  = (tx_state_reg == TX_WAIT) ? 3'h0 : 3'(tx_idx_reg + 3'h1);
  assign load_byte = dg_byte(load_idx, REPLY_ADDR, {1'b0, tx_reg_reg}, tx_data_reg, tx_crc_reg);

  assign link.dev_tx = tx_out_reg;
  assign link.dev_oe = tx_oe_reg;

  // ****************************************
  // line synchroniser
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg   <= 1'b1;
      line_reg   <= 1'b1;
      line_d_reg <= 1'b1;
    end else begin
      meta_reg   <= link.line;
      line_reg   <= meta_reg;
      line_d_reg <= line_reg;
    end
  end

  // ****************************************
  // receiver: baud measure and byte sampling
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state_reg  <= RX_IDLE;
      cnt_reg       <= '0;
      edge_reg      <= 1'b0;
      period_reg    <= RESET_BIT_CLKS;
      timer_reg     <= '0;
      bit_idx_reg   <= '0;
      shift_reg     <= '0;
      byte_idx_reg  <= '0;
      gap_reg       <= '0;
      byte_done_reg <= 1'b0;
    end else begin
      byte_done_reg <= 1'b0;
      unique case (rx_state_reg)
        RX_IDLE: begin
          if (fall && tx_state_reg == TX_IDLE) begin
            cnt_reg      <= 18'h00001;
            edge_reg     <= 1'b0;
            rx_state_reg <= RX_SYNC;
          end
        end
        RX_SYNC: begin
          cnt_reg <= cnt_reg + 18'h00001;
          if (fall && edge_reg) begin
            if (meas < MIN_BIT_CLKS) begin
              timer_reg    <= per_m1;
              gap_reg      <= '0;
              rx_state_reg <= RX_RECOVER;
            end else begin
              period_reg   <= meas;
              timer_reg    <= {1'b0, meas} + {2'b00, meas[15:1]} - 17'h00001;
              bit_idx_reg  <= 3'h4;
              shift_reg    <= {4'h0, SYNC_NIBBLE};
              byte_idx_reg <= '0;
              rx_state_reg <= RX_BITS;
            end
          end else if (fall) begin
            edge_reg <= 1'b1;
          end else if (&cnt_reg) begin
            timer_reg    <= per_m1;
            gap_reg      <= '0;
            rx_state_reg <= RX_RECOVER;
          end
        end
        RX_BITS: begin
          if (timer_reg == '0) begin
            shift_reg[bit_idx_reg] <= line_reg;
            timer_reg              <= per_m1;
            bit_idx_reg            <= bit_idx_reg + 3'h1;
            if (bit_idx_reg == 3'h7) begin
              rx_state_reg <= RX_STOP;
            end
          end else begin
            timer_reg <= timer_reg - 17'h00001;
          end
        end
        RX_STOP: begin
          if (timer_reg == '0) begin
            timer_reg <= per_m1;
            gap_reg   <= '0;
            if (!line_reg) begin
              rx_state_reg <= RX_RECOVER;
            end else begin
              byte_done_reg <= 1'b1;
              rx_state_reg  <= rx_last ? RX_IDLE : RX_GAP;
            end
          end else begin
            timer_reg <= timer_reg - 17'h00001;
          end
        end
        RX_GAP: begin
          if (fall) begin
            timer_reg    <= {1'b0, period_reg} + {2'b00, period_reg[15:1]} - 17'h00001;
            bit_idx_reg  <= '0;
            byte_idx_reg <= byte_idx_reg + 3'h1;
            rx_state_reg <= RX_BITS;
          end else if (timer_reg == '0) begin
            timer_reg <= per_m1;
            gap_reg   <= gap_reg + 7'h01;
            if (gap_reg == TIMEOUT_BITS - BYTE_BITS) begin
              gap_reg      <= '0;
              rx_state_reg <= RX_RECOVER;
            end
          end else begin
            timer_reg <= timer_reg - 17'h00001;
          end
        end
        RX_RECOVER: begin
          if (!line_reg) begin
            timer_reg <= per_m1;
            gap_reg   <= '0;
          end else if (timer_reg == '0) begin
            timer_reg <= per_m1;
            gap_reg   <= gap_reg + 7'h01;
            if (gap_reg == RECOVER_BITS - 7'h01) begin
              rx_state_reg <= RX_IDLE;
            end
          end else begin
            timer_reg <= timer_reg - 17'h00001;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // ****************************************
  // datagram check and decode
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_reg  <= CRC_SEED;
      addr_reg <= '0;
      cmd_reg  <= '0;
      data_reg <= '0;
      wr_valid <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= '0;
      rd_req   <= 1'b0;
      rd_addr  <= '0;
      dg_valid <= 1'b0;
    end else begin
      wr_valid <= 1'b0;
      rd_req   <= 1'b0;
      dg_valid <= 1'b0;
      if (byte_done_reg) begin
        if (byte_idx_reg == 3'h0) begin
          crc_reg <= crc8_byte(CRC_SEED, shift_reg);
        end else if (!rx_last) begin
          crc_reg <= crc8_byte(crc_reg, shift_reg);
        end
        if (byte_idx_reg == 3'h1) begin
          addr_reg <= shift_reg;
        end
        if (byte_idx_reg == 3'h2) begin
          cmd_reg <= shift_reg;
        end
        if (byte_idx_reg >= 3'h3 && !rx_last) begin
          data_reg <= {data_reg[23:0], shift_reg};
        end
        if (rx_last && shift_reg == crc_reg) begin
          dg_valid <= 1'b1;
          if (addr_reg == node_address) begin
            if (cmd_reg[WRITE_FLAG_POS]) begin
              wr_valid <= 1'b1;
              wr_addr  <= cmd_reg[6:0];
              wr_data  <= data_reg;
            end else begin
              rd_req  <= 1'b1;
              rd_addr <= cmd_reg[6:0];
            end
          end
        end
      end
    end
  end

  // ****************************************
  // write acknowledge counter
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_count <= ACK_RESET;
    end else if (wr_valid) begin
      ack_count <= ack_count + 8'h01;
    end
  end

  // ****************************************
  // reply transmitter
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state_reg <= TX_IDLE;
      tx_timer_reg <= '0;
      tx_bits_reg  <= '0;
      tx_frame_reg <= '1;
      tx_nbit_reg  <= '0;
      tx_idx_reg   <= '0;
      tx_crc_reg   <= CRC_SEED;
      tx_data_reg  <= '0;
      tx_reg_reg   <= '0;
      tx_out_reg   <= 1'b1;
      tx_oe_reg    <= 1'b0;
    end else begin
      if (tx_state_reg != TX_IDLE) begin
        tx_timer_reg <= tx_tick ? period_reg - 16'h0001 : tx_timer_reg - 16'h0001;
      end
      unique case (tx_state_reg)
        TX_IDLE: begin
          if (rd_req) begin
            tx_data_reg  <= rd_data;
            tx_reg_reg   <= rd_addr;
            tx_timer_reg <= period_reg - 16'h0001;
            tx_bits_reg  <= (reply_delay_setting < DELAY_MIN_STEPS ? {4'h0, DELAY_MIN_STEPS}
                            : {4'h0, reply_delay_setting}) * DELAY_STEP_BITS;
            tx_state_reg <= TX_WAIT;
          end
        end
        TX_WAIT, TX_SEND: begin
          if (tx_tick) begin
            if (tx_state_reg == TX_WAIT ? tx_bits_reg == 8'h01 : tx_nbit_reg == STOP_POS) begin
              if (tx_state_reg == TX_SEND && tx_idx_reg == WRITE_LAST) begin
                tx_bits_reg  <= RELEASE_BITS;
                tx_out_reg   <= 1'b1;
                tx_state_reg <= TX_HOLD;
              end else begin
                tx_frame_reg <= {1'b1, load_byte, 1'b0};
                tx_crc_reg   <= crc8_byte(load_idx == 3'h0 ? CRC_SEED : tx_crc_reg, load_byte);
                tx_idx_reg   <= load_idx;
                tx_nbit_reg  <= '0;
                tx_out_reg   <= 1'b0;
                tx_oe_reg    <= 1'b1;
                tx_state_reg <= TX_SEND;
              end
            end else if (tx_state_reg == TX_WAIT) begin
              tx_bits_reg <= tx_bits_reg - 8'h01;
            end else begin
              tx_frame_reg <= {1'b1, tx_frame_reg[9:1]};
              tx_out_reg   <= tx_frame_reg[1];
              tx_nbit_reg  <= tx_nbit_reg + 4'h1;
            end
          end
        end
        TX_HOLD: begin
          if (tx_tick) begin
            tx_bits_reg <= tx_bits_reg - 8'h01;
            if (tx_bits_reg == 8'h01) begin
              tx_oe_reg    <= 1'b0;
              tx_state_reg <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule : swire_device

// file: logic/swire_host.sv
// host end of the single-wire datagram link: sends requests, collects read replies
// assumes a fixed host bit rate; user commands wait for cmd_ready
module swire_host
  import swire_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  swire_if.host            link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_target,
  input  wire logic [6:0]  cmd_addr,
  input  wire logic [31:0] cmd_data,
  output logic             rsp_valid,
  output logic             rsp_ok,
  output logic [6:0]       rsp_addr,
  output logic [31:0]      rsp_data,
  output logic             rsp_timeout
);

  typedef enum logic [1:0] {H_IDLE = 2'h0, H_SEND = 2'h1, H_LISTEN = 2'h3} h_state_t;

  h_state_t    h_state_reg;
  logic [15:0] timer_reg;
  logic [9:0]  frame_reg;
  logic [3:0]  nbit_reg;
  logic [2:0]  idx_reg;
  logic [7:0]  crc_reg;
  logic        write_reg;
  logic [7:0]  target_reg;
  logic [6:0]  addr_reg;
  logic [31:0] data_reg;
  logic [7:0]  wait_reg;
  logic        out_reg;
  logic        oe_reg;
  logic        meta_reg;
  logic        line_reg;
  logic        line_d_reg;
  logic        r_busy_reg;
  logic [15:0] r_timer_reg;
  logic [3:0]  r_bit_reg;
  logic [7:0]  r_shift_reg;
  logic [2:0]  r_idx_reg;
  logic [7:0]  r_crc_reg;
  logic [7:0]  r_addr_reg;

  logic        tick;
  logic [2:0]  last_idx;
  logic [2:0]  nidx;
  logic [7:0]  nbyte;

  assign cmd_ready    = (h_state_reg == H_IDLE);
  assign tick         = (timer_reg == 16'h0000);
  assign last_idx     = write_reg ? WRITE_LAST : READ_LAST;
  assign nidx         = 3'(idx_reg + 3'h1);
  assign nbyte        = (!write_reg && nidx == READ_LAST) ? crc_reg
                      : dg_byte(nidx, target_reg, {write_reg, addr_reg}, data_reg, crc_reg);
  assign link.host_tx = out_reg;
  assign link.host_oe = oe_reg;

  // ****************************************
  // request transmitter
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      h_state_reg <= H_IDLE;
      timer_reg   <= '0;
      frame_reg   <= '1;
      nbit_reg    <= '0;
      idx_reg     <= '0;
      crc_reg     <= CRC_SEED;
      write_reg   <= 1'b0;
      target_reg  <= '0;
      addr_reg    <= '0;
      data_reg    <= '0;
      wait_reg    <= '0;
      out_reg     <= 1'b1;
      oe_reg      <= 1'b0;
      rsp_timeout <= 1'b0;
    end else begin
      rsp_timeout <= 1'b0;
      timer_reg   <= tick ? HOST_BIT_CLKS - 16'h0001 : timer_reg - 16'h0001;
      unique case (h_state_reg)
        H_IDLE: begin
          if (cmd_valid) begin
            write_reg   <= cmd_write;
            target_reg  <= cmd_target;
            addr_reg    <= cmd_addr;
            data_reg    <= cmd_data;
            frame_reg   <= {1'b1, SYNC_BYTE, 1'b0};
            crc_reg     <= crc8_byte(CRC_SEED, SYNC_BYTE);
            idx_reg     <= '0;
            nbit_reg    <= '0;
            timer_reg   <= HOST_BIT_CLKS - 16'h0001;
            out_reg     <= 1'b0;
            oe_reg      <= 1'b1;
            h_state_reg <= H_SEND;
          end
        end
        H_SEND: begin
          if (tick) begin
            if (nbit_reg != STOP_POS) begin
              frame_reg <= {1'b1, frame_reg[9:1]};
              out_reg   <= frame_reg[1];
              nbit_reg  <= nbit_reg + 4'h1;
            end else if (idx_reg == last_idx) begin
              oe_reg      <= 1'b0;
              wait_reg    <= '0;
              h_state_reg <= write_reg ? H_IDLE : H_LISTEN;
            end else begin
              frame_reg <= {1'b1, nbyte, 1'b0};
              crc_reg   <= crc8_byte(crc_reg, nbyte);
              idx_reg   <= nidx;
              nbit_reg  <= '0;
              out_reg   <= 1'b0;
            end
          end
        end
        H_LISTEN: begin
          if (rsp_valid) begin
            h_state_reg <= H_IDLE;
          end else if (tick && !r_busy_reg) begin
            wait_reg <= wait_reg + 8'h01;
            if (wait_reg == REPLY_TIMEOUT_BITS) begin
              rsp_timeout <= 1'b1;
              h_state_reg <= H_IDLE;
            end
          end
        end
        default: h_state_reg <= H_IDLE;
      endcase
    end
  end

  // ****************************************
  // reply receiver, off while sending
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg    <= 1'b1;
      line_reg    <= 1'b1;
      line_d_reg  <= 1'b1;
      r_busy_reg  <= 1'b0;
      r_timer_reg <= '0;
      r_bit_reg   <= '0;
      r_shift_reg <= '0;
      r_idx_reg   <= '0;
      r_crc_reg   <= CRC_SEED;
      r_addr_reg  <= '0;
      rsp_valid   <= 1'b0;
      rsp_ok      <= 1'b0;
      rsp_addr    <= '0;
      rsp_data    <= '0;
    end else begin
      meta_reg   <= link.line;
      line_reg   <= meta_reg;
      line_d_reg <= line_reg;
      rsp_valid  <= 1'b0;
      if (h_state_reg != H_LISTEN) begin
        r_busy_reg <= 1'b0;
        r_idx_reg  <= '0;
        r_crc_reg  <= CRC_SEED;
      end else if (!r_busy_reg) begin
        if (line_d_reg && !line_reg) begin
          r_busy_reg  <= 1'b1;
          r_bit_reg   <= '0;
          r_timer_reg <= HOST_BIT_CLKS + {1'b0, HOST_BIT_CLKS[15:1]} - 16'h0001;
        end
      end else if (r_timer_reg != 16'h0000) begin
        r_timer_reg <= r_timer_reg - 16'h0001;
      end else if (r_bit_reg != 4'h8) begin
        r_shift_reg <= {line_reg, r_shift_reg[7:1]};
        r_bit_reg   <= r_bit_reg + 4'h1;
        r_timer_reg <= HOST_BIT_CLKS - 16'h0001;
      end else begin
        r_busy_reg <= 1'b0;
        r_idx_reg  <= r_idx_reg + 3'h1;
        if (r_idx_reg != WRITE_LAST) begin
          r_crc_reg <= crc8_byte(r_crc_reg, r_shift_reg);
        end
        unique case (r_idx_reg)
          3'h1:    r_addr_reg <= r_shift_reg;
          3'h2:    rsp_addr <= r_shift_reg[6:0];
          3'h7: begin
            rsp_valid <= 1'b1;
            rsp_ok    <= (r_shift_reg == r_crc_reg) && (r_addr_reg == REPLY_ADDR);
          end
          default: rsp_data <= {rsp_data[23:0], r_shift_reg};
        endcase
      end
    end
  end

endmodule : swire_host

// file: verif/swire_link_chk.sv
// wire checks on the shared single wire
// assumes one clock and the interface signals as inputs
module swire_link_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_tx,
  input wire logic host_oe,
  input wire logic dev_tx,
  input wire logic dev_oe,
  input wire logic line
);
  // ********
  // run counters
  // ********
  logic [15:0] hold, don, hon, gap, lowd;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {hold, don, hon, gap, lowd} <= '0;
    end else begin
      hold <= (dev_oe && dev_tx) ? hold + 16'h1 : 16'h0;
      don  <= dev_oe ? don + 16'h1 : 16'h0;
      hon  <= host_oe ? hon + 16'h1 : 16'h0;
      gap  <= host_oe ? 16'h0 : gap + 16'h1;
      lowd <= (dev_oe && !dev_tx) ? lowd + 16'h1 : 16'h0;
    end
  end
  property p_idle; (!dev_oe |-> dev_tx) and (!host_oe |-> host_tx); endproperty
  a_idle: assert property (p_idle) else $error("released end not at idle high level");
  property p_one; !(host_oe && dev_oe); endproperty
  a_one: assert property (p_one) else $error("both ends drive");
  property p_start; $rose(dev_oe) |-> !dev_tx; endproperty
  a_start: assert property (p_start) else $error("reply not at start bit");
  property p_hold; $fell(dev_oe) |-> hold inside {[480:1310]}; endproperty
  a_hold: assert property (p_hold) else $error("release time wrong");
  property p_delay; $rose(dev_oe) |-> gap >= 16'd700; endproperty
  a_delay: assert property (p_delay) else $error("reply too early");
  property p_bit; dev_oe && $rose(dev_tx) |-> lowd >= 16'd96; endproperty
  a_bit: assert property (p_bit) else $error("reply bit too short");
  property p_hlen; $fell(host_oe) |-> hon inside {[3990:4010], [7990:8010]}; endproperty
  a_hlen: assert property (p_hlen) else $error("request length wrong");
  property p_dlen; $fell(dev_oe) |-> don inside {[8350:8450]}; endproperty
  a_dlen: assert property (p_dlen) else $error("reply length wrong");
  c_reply: cover property ($rose(dev_oe));
  c_write: cover property ($fell(host_oe) && hon > 16'd7000);
  c_read: cover property ($fell(host_oe) && hon < 16'd5000);
endmodule : swire_link_chk

// file: verif/test_single_wire_uart_crc_slave.sv
// bench joining host and device ends on one wire
// assumes design package, interface and checker compiled first
module test_single_wire_uart_crc_slave;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, cmd_valid, cmd_ready, cmd_write, wr_valid, rd_req, dg_valid, rsp_valid, rsp_ok, rsp_timeout;
  logic [7:0] node_address, cmd_target, ack_count;
  logic [3:0] reply_delay_setting;
  logic [6:0] cmd_addr, wr_addr, rd_addr, rsp_addr;
  logic [31:0] cmd_data, rd_data, wr_data, rsp_data;
  int err_total = 0, n_tests = 0, n_wr = 0, n_dg = 0, n_rsp = 0, n_to = 0, cyc = 0, t_req = 0, t_oe = 0;
  swire_if link ();
  swire_device u_swire_device (.clk, .rst, .link, .node_address, .reply_delay_setting, .rd_data,
    .wr_valid, .wr_addr, .wr_data, .rd_req, .rd_addr, .dg_valid, .ack_count);
  swire_host u_swire_host (.clk, .rst, .link, .cmd_valid, .cmd_ready, .cmd_write, .cmd_target,
    .cmd_addr, .cmd_data, .rsp_valid, .rsp_ok, .rsp_addr, .rsp_data, .rsp_timeout);
  swire_link_chk u_swire_link_chk (.clk, .rst, .host_tx(link.host_tx), .host_oe(link.host_oe),
    .dev_tx(link.dev_tx), .dev_oe(link.dev_oe), .line(link.line));
  // ********
  // helpers and tests
  // ********
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc++;
    n_wr += int'(wr_valid === 1'b1);
    n_dg += int'(dg_valid === 1'b1);
    n_rsp += int'(rsp_valid === 1'b1);
    n_to += int'(rsp_timeout === 1'b1);
    if (rd_req === 1'b1) t_req = cyc;
    if (link.dev_oe === 1'b1 && t_oe <= t_req) t_oe = cyc;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] crc_ref(input logic [7:0] b [8]);
    logic [7:0] c = 8'h00;
    for (int i = 0; i < 7; i++)
      for (int j = 0; j < 8; j++) c = (c[7] ^ b[i][j]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction : crc_ref
  task automatic send(input logic w, input logic [7:0] t, input logic [6:0] a, input logic [31:0] d);
    cmd_write <= w;
    cmd_target <= t;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : send
  task automatic done();
    int k;
    for (k = 0; k < 20000; k++) begin
      @(negedge clk);
      if (cmd_ready === 1'b1 && link.dev_oe === 1'b0) break;
    end
    if (k == 20000) err_total++;
    repeat (300) @(posedge clk);
  endtask : done
  task automatic t_write(input logic [7:0] t, input logic [31:0] d);
    int w = n_wr;
    int g = n_dg;
    logic [7:0] a = ack_count;
    send(1'b1, t, 7'h15, d);
    done();
    check("write strobe", 32'(n_wr - w), 32'(t == 8'h00));
    check("ack count", 32'(ack_count), 32'(8'(a + 8'(t == 8'h00))));
    check("check ok", 32'(n_dg - g), 32'h1);
    if (t == 8'h00) check("write data", wr_data, d);
    if (t == 8'h00) check("write addr", 32'(wr_addr), 32'h15);
    $display("test write %h done", t);
  endtask : t_write
  task automatic t_read(input logic [3:0] s, input logic [31:0] d);
    logic [7:0] q [8];
    logic [7:0] a = ack_count;
    int r = n_rsp;
    rd_data <= d;
    reply_delay_setting <= s;
    fork
      send(1'b0, 8'h00, 7'h2A, 32'h0);
      for (int k = 0; k < 8; k++) begin
        if (k == 0) @(posedge link.dev_oe);
        else @(negedge link.line);
        repeat (150) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
          q[k][i] = link.line;
          repeat (100) @(negedge clk);
        end
      end
    join
    done();
    check("reply sync", 32'(q[0][3:0]), 32'h5);
    check("reply addr", 32'(q[1]), 32'hFF);
    check("reply reg", 32'(q[2]), 32'h2A);
    check("reply data", {q[3], q[4], q[5], q[6]}, d);
    check("reply crc", 32'(q[7]), 32'(crc_ref(q)));
    check("reply delay", 32'((t_oe - t_req) / 100), 32'(((s == 4'h0) ? 1 : s) * 8));
    check("read addr", 32'(rd_addr), 32'h2A);
    check("reply seen", 32'(n_rsp - r), 32'h1);
    check("reply ok", 32'(rsp_ok), 32'h1);
    check("no timeout", 32'(n_to), 32'h0);
    check("reply word", rsp_data, d);
    check("ack after read", 32'(ack_count), 32'(a));
    $display("test read %h done", s);
  endtask : t_read
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    {rst, cmd_valid, cmd_write, cmd_target, cmd_addr, cmd_data} = {1'b1, 49'h0};
    {node_address, reply_delay_setting, rd_data} = 44'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (1500) @(posedge clk);
    check("ack reset", 32'(ack_count), 32'h0);
    t_write(8'h00, 32'hA5C3_0F81);
    t_write(8'h03, 32'h1234_5678);
    t_write(8'h00, 32'hFFFF_0000);
    t_read(4'h0, 32'h8001_7EFE);
    t_read(4'h2, 32'h0F0F_F0F0);
    summarize();
  end
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule : test_single_wire_uart_crc_slave
